// *** src/addr_ctl_pkg.sv ***
package addr_ctl_pkg;

    localparam int OCTETS_PER_SUB = 7;
    localparam int CALL_CHARS = 6;
    localparam int MAX_RPT = 8;
    localparam int MAX_SUBS = 10;
    localparam logic [7:0] SPACE_CHAR = 8'h20;
    localparam logic [1:0] RSV_IDLE = 2'h3;
    localparam int EXT_BIT = 0;
    localparam int CR_BIT = 7;
    localparam int PF_BIT = 4;
    localparam logic [2:0] OCT_IDX_RST = 3'h0;
    localparam logic [3:0] SUB_IDX_RST = 4'h0;
    localparam logic [2:0] BIT_IDX_RST = 3'h0;

    typedef enum logic [1:0]
    {
        FRM_INFO = 2'h0,
        FRM_SUPV = 2'h1,
        FRM_UNNUM = 2'h3
    } frame_kind_t;

    typedef struct packed
    {
        logic [5:0][6:0] call;
        logic [3:0] ssid;
        logic cr_h;
        logic [1:0] rsv;
    } station_t;

    typedef struct packed
    {
        frame_kind_t kind;
        logic [2:0] nr;
        logic [2:0] ns;
        logic pf;
        logic [1:0] sfunc;
        logic [4:0] umod;
    } ctl_info_t;

endpackage

// *** src/addr_ctl_codec.sv ***
`timescale 1ns/100ps
`default_nettype none

module addr_ctl_codec
(
    input wire logic mclk_i,
    input wire logic rst_i,
    // Transmit request
    input wire logic tx_start_i,
    input wire addr_ctl_pkg::station_t tx_dest_i,
    input wire addr_ctl_pkg::station_t tx_src_i,
    input wire addr_ctl_pkg::station_t [7:0] tx_rpt_i,
    input wire logic [3:0] tx_rpt_cnt_i,
    output logic tx_busy_o,
    // Serial bit out toward the bit engine
    output logic tx_bit_o,
    output logic tx_bit_valid_o,
    output logic tx_last_o,
    input wire logic tx_bit_ready_i,
    // Receive octet stream from the bit engine
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_octet_i,
    input wire logic rx_sof_i,
    input wire logic via_rpt_i,
    output logic rx_addr_done_o,
    output logic rx_addr_err_o,
    output logic rx_discard_o,
    output logic [3:0] rx_rpt_cnt_o,
    output logic rx_ctl_valid_o,
    output addr_ctl_pkg::ctl_info_t rx_ctl_o
);

    function automatic logic [7:0] id_octet(input addr_ctl_pkg::station_t st, input logic ext);
        id_octet = {st.cr_h, addr_ctl_pkg::RSV_IDLE, st.ssid, ext};
    endfunction

    function automatic logic [7:0] call_octet(input addr_ctl_pkg::station_t st, input logic [2:0] i);
        logic [6:0] c;
        c = st.call[3'd5 - i];
        if (c == 7'h00)
            c = addr_ctl_pkg::SPACE_CHAR[6:0];
        call_octet = {c, 1'b0};
    endfunction

    // Transmit side
    typedef enum logic [1:0]
    {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;

    tx_state_t tx_state_q;
    logic [2:0] tx_oct_q;
    logic [3:0] tx_sub_q;
    logic [2:0] tx_bit_q;
    logic [3:0] tx_nsub_q;
    addr_ctl_pkg::station_t tx_dest_q;
    addr_ctl_pkg::station_t tx_src_q;
    addr_ctl_pkg::station_t [7:0] tx_rpt_q;
    logic [7:0] tx_oct_d;
    addr_ctl_pkg::station_t cur_st;
    logic tx_final;
    logic tx_step;

    assign tx_busy_o = (tx_state_q == TX_SEND);
    assign tx_bit_valid_o = (tx_state_q == TX_SEND);
    assign tx_step = tx_bit_valid_o && tx_bit_ready_i;

    always_comb
    begin
        // Destination, then source, then repeaters in chain order
        if (tx_sub_q == 4'h0)
            cur_st = tx_dest_q;
        else if (tx_sub_q == 4'h1)
            cur_st = tx_src_q;
        else
            cur_st = tx_rpt_q[3'(tx_sub_q - 4'h2)];
        tx_final = (tx_sub_q == tx_nsub_q - 4'h1)
            && (tx_oct_q == 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1));
        if (tx_oct_q == 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1))
            tx_oct_d = id_octet(cur_st, tx_final);
        else
            tx_oct_d = call_octet(cur_st, tx_oct_q);
    end

    assign tx_bit_o = tx_oct_d[tx_bit_q];
    assign tx_last_o = tx_final && (tx_bit_q == 3'h7);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_state_q <= TX_IDLE;
            tx_oct_q <= addr_ctl_pkg::OCT_IDX_RST;
            tx_sub_q <= addr_ctl_pkg::SUB_IDX_RST;
            tx_bit_q <= addr_ctl_pkg::BIT_IDX_RST;
            tx_nsub_q <= 4'h2;
        end
        else
        begin
            unique case (tx_state_q)
                TX_IDLE:
                begin
                    if (tx_start_i)
                    begin
                        tx_state_q <= TX_SEND;
                        tx_oct_q <= addr_ctl_pkg::OCT_IDX_RST;
                        tx_sub_q <= addr_ctl_pkg::SUB_IDX_RST;
                        tx_bit_q <= addr_ctl_pkg::BIT_IDX_RST;
                        tx_nsub_q <= 4'h2 + ((tx_rpt_cnt_i > 4'h8) ? 4'h8 : tx_rpt_cnt_i);
                    end
                end
                TX_SEND:
                begin
                    if (tx_step)
                    begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q == 3'h7)
                        begin
                            if (tx_final)
                                tx_state_q <= TX_IDLE;
                            else if (tx_oct_q == 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1))
                            begin
                                tx_oct_q <= addr_ctl_pkg::OCT_IDX_RST;
                                tx_sub_q <= tx_sub_q + 4'h1;
                            end
                            else
                                tx_oct_q <= tx_oct_q + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Capture of stations at start; outgoing repeater flags cleared
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_dest_q <= '0;
            tx_src_q <= '0;
            tx_rpt_q <= '0;
        end
        else if (tx_state_q == TX_IDLE && tx_start_i)
        begin
            tx_dest_q <= tx_dest_i;
            tx_src_q <= tx_src_i;
            for (int k = 0; k < addr_ctl_pkg::MAX_RPT; k++)
            begin
                tx_rpt_q[k] <= tx_rpt_i[k];
                tx_rpt_q[k].cr_h <= 1'b0;
            end
        end
    end

    // Receive side
    typedef enum logic [2:0]
    {
        RX_ADDR = 3'b001,
        RX_CTL = 3'b010,
        RX_REST = 3'b100
    } rx_state_t;

    rx_state_t rx_state_q;
    logic [2:0] rx_oct_q;
    logic [3:0] rx_sub_q;
    logic rx_last_h_q;
    logic rx_err_d;
    logic [2:0] rx_oct_v;
    logic [3:0] rx_sub_v;

    always_comb
    begin
        // Start octet judged as first destination octet, not by stale indices
        rx_oct_v = rx_sof_i ? addr_ctl_pkg::OCT_IDX_RST : rx_oct_q;
        rx_sub_v = rx_sof_i ? addr_ctl_pkg::SUB_IDX_RST : rx_sub_q;
        rx_err_d = 1'b0;
        if (rx_octet_i[addr_ctl_pkg::EXT_BIT]
            && (rx_oct_v != 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1) || rx_sub_v == 4'h0))
            rx_err_d = 1'b1;
        if (rx_oct_v == 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1)
            && !rx_octet_i[addr_ctl_pkg::EXT_BIT]
            && rx_sub_v == 4'(addr_ctl_pkg::MAX_SUBS - 1))
            rx_err_d = 1'b1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rx_state_q <= RX_REST;
            rx_oct_q <= addr_ctl_pkg::OCT_IDX_RST;
            rx_sub_q <= addr_ctl_pkg::SUB_IDX_RST;
            rx_last_h_q <= 1'b0;
            rx_addr_done_o <= 1'b0;
            rx_addr_err_o <= 1'b0;
            rx_discard_o <= 1'b0;
            rx_rpt_cnt_o <= 4'h0;
        end
        else
        begin
            rx_addr_done_o <= 1'b0;
            if (rx_valid_i && rx_sof_i)
            begin
                rx_state_q <= RX_ADDR;
                rx_oct_q <= 3'h1;
                rx_sub_q <= addr_ctl_pkg::SUB_IDX_RST;
                rx_addr_err_o <= rx_err_d;
                rx_discard_o <= 1'b0;
                rx_rpt_cnt_o <= 4'h0;
                if (rx_err_d)
                    rx_state_q <= RX_REST;
            end
            else if (rx_valid_i && rx_state_q == RX_ADDR)
            begin
                if (rx_err_d)
                begin
                    rx_addr_err_o <= 1'b1;
                    rx_state_q <= RX_REST;
                end
                else if (rx_oct_q == 3'(addr_ctl_pkg::OCTETS_PER_SUB - 1))
                begin
                    rx_oct_q <= addr_ctl_pkg::OCT_IDX_RST;
                    rx_sub_q <= rx_sub_q + 4'h1;
                    if (rx_sub_q >= 4'h2)
                        rx_last_h_q <= rx_octet_i[addr_ctl_pkg::CR_BIT];
                    if (rx_octet_i[addr_ctl_pkg::EXT_BIT])
                    begin
                        rx_state_q <= RX_CTL;
                        rx_addr_done_o <= 1'b1;
                        rx_rpt_cnt_o <= rx_sub_q - 4'h1;
                        // Uplink frame: next-to-last repeater, or the only one, not yet passed
                        rx_discard_o <= via_rpt_i && (rx_sub_q >= 4'h2)
                            && !((rx_sub_q == 4'h2) ? rx_octet_i[addr_ctl_pkg::CR_BIT]
                                 : rx_last_h_q);
                    end
                end
                else
                    rx_oct_q <= rx_oct_q + 3'h1;
            end
            else if (rx_valid_i && rx_state_q == RX_CTL)
                rx_state_q <= RX_REST;
        end
    end

    // Control field classification
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rx_ctl_valid_o <= 1'b0;
            rx_ctl_o <= '0;
        end
        else
        begin
            rx_ctl_valid_o <= rx_valid_i && !rx_sof_i && rx_state_q == RX_CTL;
            if (rx_valid_i && !rx_sof_i && rx_state_q == RX_CTL)
            begin
                rx_ctl_o.pf <= rx_octet_i[addr_ctl_pkg::PF_BIT];
                rx_ctl_o.nr <= rx_octet_i[7:5];
                rx_ctl_o.ns <= rx_octet_i[3:1];
                rx_ctl_o.sfunc <= rx_octet_i[3:2];
                rx_ctl_o.umod <= {rx_octet_i[7:5], rx_octet_i[3:2]};
                if (!rx_octet_i[0])
                    rx_ctl_o.kind <= addr_ctl_pkg::FRM_INFO;
                else if (!rx_octet_i[1])
                    rx_ctl_o.kind <= addr_ctl_pkg::FRM_SUPV;
                else
                    rx_ctl_o.kind <= addr_ctl_pkg::FRM_UNNUM;
            end
        end
    end

    property p_tx_ext_zero;
        @(posedge mclk_i) disable iff (rst_i)
        (tx_step && tx_bit_q == 3'h0 && !tx_final) |-> !tx_bit_o;
    endproperty
    a_tx_ext_zero: assert property (p_tx_ext_zero) else $error("Extension set early");

    property p_tx_ext_one;
        @(posedge mclk_i) disable iff (rst_i)
        (tx_step && tx_bit_q == 3'h0 && tx_final) |-> tx_bit_o;
    endproperty
    a_tx_ext_one: assert property (p_tx_ext_one) else $error("Final extension clear");

    property p_tx_bit_order;
        @(posedge mclk_i) disable iff (rst_i)
        (tx_step && tx_bit_q == 3'h3) |=> (tx_bit_q == 3'h4);
    endproperty
    a_tx_bit_order: assert property (p_tx_bit_order) else $error("Bit order broken");

    property p_tx_rsv;
        @(posedge mclk_i) disable iff (rst_i)
        (tx_busy_o && tx_oct_q == 3'h6) |-> (tx_oct_d[6:5] == 2'h3);
    endproperty
    a_tx_rsv: assert property (p_tx_rsv) else $error("Reserved bits not one");

    property p_tx_h_clear;
        @(posedge mclk_i) disable iff (rst_i)
        (tx_busy_o && tx_sub_q >= 4'h2 && tx_oct_q == 3'h6) |-> !tx_oct_d[7];
    endproperty
    a_tx_h_clear: assert property (p_tx_h_clear) else $error("Repeated flag sent");

    property p_tx_sub_limit;
        @(posedge mclk_i) disable iff (rst_i)
        tx_busy_o |-> (tx_sub_q < 4'(addr_ctl_pkg::MAX_SUBS));
    endproperty
    a_tx_sub_limit: assert property (p_tx_sub_limit) else $error("Too many subfields");

    property p_rx_info;
        @(posedge mclk_i) disable iff (rst_i)
        (rx_valid_i && !rx_sof_i && rx_state_q == RX_CTL && !rx_octet_i[0])
        |=> (rx_ctl_valid_o && rx_ctl_o.kind == addr_ctl_pkg::FRM_INFO);
    endproperty
    a_rx_info: assert property (p_rx_info) else $error("Info frame misclassified");

    property p_rx_unnum;
        @(posedge mclk_i) disable iff (rst_i)
        (rx_valid_i && !rx_sof_i && rx_state_q == RX_CTL && rx_octet_i[1:0] == 2'h3)
        |=> (rx_ctl_o.kind == addr_ctl_pkg::FRM_UNNUM && rx_ctl_o.pf == $past(rx_octet_i[4]));
    endproperty
    a_rx_unnum: assert property (p_rx_unnum) else $error("Unnumbered misdecoded");

    property p_rx_err_short;
        @(posedge mclk_i) disable iff (rst_i)
        (rx_valid_i && rx_state_q == RX_ADDR && !rx_sof_i && rx_octet_i[0]
         && rx_oct_q != 3'h6) |=> rx_addr_err_o;
    endproperty
    a_rx_err_short: assert property (p_rx_err_short) else $error("Bad boundary missed");

    property p_rx_discard;
        @(posedge mclk_i) disable iff (rst_i)
        rx_discard_o |-> (via_rpt_i || $past(via_rpt_i)) && rx_rpt_cnt_o != 4'h0;
    endproperty
    a_rx_discard: assert property (p_rx_discard) else $error("Discard without repeater");

endmodule // addr_ctl_codec

`default_nettype wire

// *** tb/bit_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
module bit_sink
(
    input wire logic mclk_i,
    input wire logic bit_i,
    input wire logic valid_i,
    input wire logic slow_i,
    input wire logic last_i,
    output logic ready_o
);
    logic [7:0] oct [0:95];
    logic [7:0] sh;
    int n;
    int b;
    int last_pos;
    initial
    begin
        ready_o = 1'b1;
        last_pos = -1;
        sh = 8'h00;
        n = 0;
        b = 0;
    end
    // Slow mode takes a bit only every other cycle
    always @(posedge mclk_i)
    begin
        if (valid_i === 1'b1 && ready_o)
        begin
            // Position of the first bit marked last
            if (last_i === 1'b1 && last_pos < 0)
                last_pos = n * 8 + b;
            sh = {bit_i, sh[7:1]};
            b = b + 1;
            if (b == 8)
            begin
                oct[n] = sh;
                n = n + 1;
                b = 0;
            end
        end
        ready_o <= #1 slow_i ? !ready_o : 1'b1;
    end
endmodule // bit_sink
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic [7:0] c; addr_ctl_pkg::frame_kind_t k;} row_t;
    logic mclk_i, rst_i, tx_start_i, tx_busy_o, tx_bit_o, tx_bit_valid_o, tx_last_o;
    logic rdy, slow, rx_valid_i, rx_sof_i, via_rpt_i, rx_addr_done_o, rx_addr_err_o;
    logic rx_discard_o, rx_ctl_valid_o, seen_d, seen_c;
    logic [3:0] tx_rpt_cnt_i, rx_rpt_cnt_o;
    logic [7:0] rx_octet_i;
    addr_ctl_pkg::station_t tx_dest_i, tx_src_i;
    addr_ctl_pkg::station_t [7:0] rpt;
    addr_ctl_pkg::ctl_info_t rx_ctl_o, cq;
    logic [7:0] fq [$];
    row_t rows [9];
    int fails = 0;
    int comparisons = 0;
    addr_ctl_codec DUT (.mclk_i(mclk_i), .rst_i(rst_i), .tx_start_i(tx_start_i),
        .tx_dest_i(tx_dest_i), .tx_src_i(tx_src_i), .tx_rpt_i(rpt),
        .tx_rpt_cnt_i(tx_rpt_cnt_i), .tx_busy_o(tx_busy_o), .tx_bit_o(tx_bit_o),
        .tx_bit_valid_o(tx_bit_valid_o), .tx_last_o(tx_last_o), .tx_bit_ready_i(rdy),
        .rx_valid_i(rx_valid_i), .rx_octet_i(rx_octet_i), .rx_sof_i(rx_sof_i),
        .via_rpt_i(via_rpt_i), .rx_addr_done_o(rx_addr_done_o),
        .rx_addr_err_o(rx_addr_err_o), .rx_discard_o(rx_discard_o),
        .rx_rpt_cnt_o(rx_rpt_cnt_o), .rx_ctl_valid_o(rx_ctl_valid_o), .rx_ctl_o(rx_ctl_o));
    bit_sink s (.mclk_i(mclk_i), .bit_i(tx_bit_o), .valid_i(tx_bit_valid_o),
        .slow_i(slow), .last_i(tx_last_o), .ready_o(rdy));
    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = !mclk_i;
    end
    // Catch one-cycle pulses in the cycle they stand
    always @(posedge mclk_i)
    begin
        if (rx_addr_done_o === 1'b1)
            seen_d <= 1'b1;
        if (rx_ctl_valid_o === 1'b1)
        begin
            seen_c <= 1'b1;
            cq <= rx_ctl_o;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic addr_ctl_pkg::station_t mk(string c, logic [3:0] id, logic f);
        mk = '0;
        for (int i = 0; i < 6; i++)
            mk.call[5 - i] = (i < c.len()) ? 7'(c[i]) : 7'h00;
        mk.ssid = id;
        mk.cr_h = f;
    endfunction
    task automatic sub(string c, logic [3:0] id, logic f, logic ext);
        for (int i = 0; i < 6; i++)
            fq.push_back((i < c.len()) ? {7'(c[i]), 1'b0} : 8'h40);
        fq.push_back({f, 2'h3, id, ext});
    endtask
    task automatic rx_frame();
        seen_d = 1'b0;
        seen_c = 1'b0;
        foreach (fq[i])
        begin
            rx_sof_i = (i == 0);
            rx_octet_i = fq[i];
            rx_valid_i = 1'b1;
            @(posedge mclk_i);
            #1;
        end
        rx_valid_i = 1'b0;
        rx_sof_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    task automatic tx_run(int nr);
        s.n = 0;
        s.last_pos = -1;
        tx_rpt_cnt_i = nr[3:0];
        tx_start_i = 1'b1;
        @(posedge mclk_i);
        #1;
        tx_start_i = 1'b0;
        for (int i = 0; i < 3000 && tx_busy_o !== 1'b0; i++)
            @(posedge mclk_i);
        #1;
        chk(s.n[7:0], 8'(fq.size()));
        chk({7'h00, s.last_pos == fq.size() * 8 - 1}, 8'h01);
        foreach (fq[i])
            chk(s.oct[i], fq[i]);
    endtask
    initial
    begin
        #(8 * 40000);
        fails++;
        wrap_up();
    end
    initial
    begin
        rst_i = 1'b1;
        tx_start_i = 1'b0;
        tx_rpt_cnt_i = 4'h0;
        rpt = '0;
        tx_dest_i = '0;
        tx_src_i = '0;
        slow = 1'b0;
        rx_valid_i = 1'b0;
        rx_sof_i = 1'b0;
        rx_octet_i = 8'h00;
        via_rpt_i = 1'b0;
        rows = '{'{8'h3E, addr_ctl_pkg::FRM_INFO}, '{8'h00, addr_ctl_pkg::FRM_INFO},
            '{8'h01, addr_ctl_pkg::FRM_SUPV}, '{8'h05, addr_ctl_pkg::FRM_SUPV},
            '{8'hF9, addr_ctl_pkg::FRM_SUPV}, '{8'h3F, addr_ctl_pkg::FRM_UNNUM},
            '{8'h13, addr_ctl_pkg::FRM_UNNUM}, '{8'hEF, addr_ctl_pkg::FRM_UNNUM},
            '{8'hAA, addr_ctl_pkg::FRM_INFO}};
        repeat (20) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        chk({tx_busy_o, tx_bit_valid_o, rx_addr_err_o, rx_discard_o}, 8'h00);
        $display("Reset test done");
        foreach (rows[r])
        begin
            fq.delete();
            sub("DEST", 4'h0, 1'b1, 1'b0);
            sub("SOURCE", 4'h0, 1'b0, 1'b1);
            fq.push_back(rows[r].c);
            rx_frame();
            chk({seen_d, seen_c, rx_addr_err_o, rx_rpt_cnt_o}, 8'h60);
            chk({6'h00, cq.kind}, {6'h00, rows[r].k});
            if (rows[r].k == addr_ctl_pkg::FRM_INFO)
                chk({cq.nr, cq.pf, cq.ns, 1'b0}, {rows[r].c[7:1], 1'b0});
            else if (rows[r].k == addr_ctl_pkg::FRM_SUPV)
                chk({cq.nr, cq.pf, cq.sfunc, 2'h1}, rows[r].c);
            else
                chk({cq.umod[4:2], cq.pf, cq.umod[1:0], 2'h3}, rows[r].c);
        end
        $display("Control table done");
        via_rpt_i = 1'b1;
        for (int h = 0; h < 2; h++)
        begin
            fq.delete();
            sub("DEST", 4'h0, 1'b1, 1'b0);
            sub("SOURCE", 4'h0, 1'b0, 1'b0);
            sub("RPTA", 4'h1, h[0], 1'b1);
            fq.push_back(8'h3E);
            rx_frame();
            chk({rx_discard_o, rx_rpt_cnt_o}, {!h[0], 4'h1});
        end
        $display("Uplink discard done");
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b1);
        fq.push_back(8'h3E);
        rx_frame();
        chk({seen_d, rx_addr_err_o}, 8'h01);
        // Extension set inside a call octet
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b0);
        fq[2] = fq[2] | 8'h01;
        sub("SOURCE", 4'h0, 1'b0, 1'b1);
        fq.push_back(8'h3E);
        rx_frame();
        chk({seen_d, seen_c, rx_addr_err_o}, 8'h01);
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b0);
        sub("SOURCE", 4'h0, 1'b0, 1'b0);
        for (int i = 0; i < 9; i++)
            sub("N0CALL", 4'h2, 1'b1, i == 8);
        fq.push_back(8'h01);
        rx_frame();
        chk({seen_d, seen_c, rx_addr_err_o}, 8'h01);
        // Clean frame right after an error left the indices mid-field
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b0);
        sub("SOURCE", 4'h0, 1'b0, 1'b1);
        fq.push_back(8'h3E);
        rx_frame();
        chk({seen_d, seen_c, rx_addr_err_o, rx_discard_o}, 8'h0C);
        $display("Address error done");
        tx_dest_i = mk("DEST", 4'h0, 1'b1);
        tx_src_i = mk("SOURCE", 4'h0, 1'b0);
        for (int i = 0; i < 8; i++)
            rpt[i] = mk("RPT", i[3:0], 1'b1);
        slow = 1'b1;
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b0);
        sub("SOURCE", 4'h0, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++)
            sub("RPT", i[3:0], 1'b0, i == 7);
        // Count above eight is clamped to eight repeaters
        tx_run(12);
        slow = 1'b0;
        fq.delete();
        sub("DEST", 4'h0, 1'b1, 1'b0);
        sub("SOURCE", 4'h0, 1'b0, 1'b1);
        tx_run(0);
        $display("Transmit done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
